// ---- lpo_pkg.sv ----
// package: register map, reset values and timing for the laser power and observation registers
`default_nettype none
package lpo_pkg;
	// ****************************************************
	// register offsets
	// ****************************************************
	localparam logic [6:0] LPO_ADDR_LASER_CFG = 7'h2c;
	localparam logic [6:0] LPO_ADDR_LASER_CMP = 7'h2d;
	localparam logic [6:0] LPO_ADDR_OBSERVE = 7'h3d;
	localparam logic [6:0] LPO_ADDR_INV_ID = 7'h3f;
	localparam logic [6:0] LPO_ADDR_PIXEL_STREAM = 7'h40;
	localparam logic [6:0] LPO_ADDR_MOTION_STREAM = 7'h50;
	localparam logic [6:0] LPO_ADDR_FW_STREAM = 7'h60;
	// ****************************************************
	// reset values and fields
	// ****************************************************
	localparam logic [7:0] LPO_RST_LASER_CFG = 8'h7f;
	localparam logic [7:0] LPO_RST_LASER_CMP = 8'h80;
	localparam logic [7:0] LPO_RST_OBSERVE = 8'h00;
	localparam logic [7:0] LPO_OBS_IMPL_MASK = 8'ha3;
	localparam int LPO_OBS_FW_BIT = 7;
	localparam int LPO_OBS_PD_BIT = 5;
	localparam int LPO_OBS_F1_BIT = 1;
	localparam int LPO_OBS_F0_BIT = 0;
	localparam int LPO_MATCH_BIT = 7;
	localparam logic [6:0] LPO_DAC_MIN_CURRENT = 7'h7f;
	localparam logic [2:0] LPO_MOTION_LEN = 3'h7;
	// ****************************************************
	// timing
	// ****************************************************
	localparam int LPO_CLK_MHZ = 50;
	localparam int LPO_TEST_PHASE_US = 12;
	localparam int LPO_TEST_PHASE_CYC = LPO_TEST_PHASE_US * LPO_CLK_MHZ;
	typedef enum logic [1:0] {LPO_ST_IDLE, LPO_ST_HIGH, LPO_ST_LOW, LPO_ST_FAULT} lpo_test_t;
endpackage : lpo_pkg
`default_nettype wire

// ---- lpo_regs.sv ----
// module: laser current, fault self-test, observation and stream registers
`default_nettype none
// Function
// R1 - programmed laser code applies only when complement register is its exact inverse
// R2 - mismatched pair forces the DAC to its lowest current code
// R3 - each laser config write starts a drive pin stuck-low/stuck-high test
// R4 - during test enable pin high, drive pulses high then low 12us each
// R5 - no fault found returns enable and drive pins to normal operation
// R6 - lower seven config bits set the DAC; each step drops current by 1/192
// R7 - code zero is full current, all ones is minimum current
// R8 - host sets the bin-match bit to suit the fitted laser diode
// R9 - config and complement may be written in either order
// R10 - writing zero to observation clears all bits; processes set them again
// R11 - host clears observation, waits, then reads active processes
// R12 - top observation bit reads one while running downloaded firmware
// R13 - observation bit five set when a powerdown pulse is detected
// R14 - observation bits one and zero set once per frame; rest reserved
// R15 - inverse id register returns inverse of product identification
// R16 - pixel stream address gives sequential pixel reads
// R17 - motion stream address streams seven motion values in order
// R18 - firmware stream address accepts written firmware bytes
// R19 - reserved addresses do nothing and read zero; here an access to one still restarts the motion stream at status
module lpo_regs
	import lpo_pkg::*;
#(
	parameter logic [7:0] PRODUCT_IDENTIFICATION = 8'h5a, // arbitrary value
	parameter int TEST_CYC = LPO_TEST_PHASE_CYC
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	// register access port
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [6:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	// core status and stream sources
	input wire logic i_fw_running,
	input wire logic i_powerdown_pulse,
	input wire logic i_frame_tick,
	input wire logic [7:0] i_pixel_data,
	input wire logic [55:0] i_motion_data,
	output logic o_pixel_next,
	output logic o_fw_valid,
	output logic [7:0] o_fw_data,
	// laser pins
	input wire logic i_laser_drive_sense,
	output logic o_laser_drive_output,
	output logic o_laser_enable_low,
	output logic [6:0] o_laser_dac_code,
	output logic o_bin_match,
	output logic o_laser_fault
);
	logic [7:0] cfg_ff;
	logic [7:0] cmp_ff;
	logic [7:0] obs_ff;
	logic [2:0] mot_idx_ff;
	lpo_test_t tst_ff;
	logic [15:0] tcnt_ff;
	logic [7:0] nxt_rdata;
	logic [7:0] nxt_obs;

	function automatic logic sel(input logic [6:0] a, input logic [6:0] b);
		return a == b;
	endfunction : sel

	// ****************************************************
	// laser configuration pair
	// ****************************************************
	// no ordering lock; either register may be written at any time [R9]
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cfg_ff <= LPO_RST_LASER_CFG;
			cmp_ff <= LPO_RST_LASER_CMP;
		end else begin
			if (i_wr && sel(i_addr, LPO_ADDR_LASER_CFG)) begin
				cfg_ff <= i_wdata;
			end
			if (i_wr && sel(i_addr, LPO_ADDR_LASER_CMP)) begin
				cmp_ff <= i_wdata;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_laser_dac_code <= LPO_DAC_MIN_CURRENT;
			o_bin_match <= 1'b0;
		end else begin
			o_bin_match <= cfg_ff[LPO_MATCH_BIT];
			// code 0 = 100 %, each count lowers by 1/192 in the analog DAC [R6] [R7]
			if (cmp_ff == ~cfg_ff) begin
				o_laser_dac_code <= cfg_ff[6:0]; // [R1]
			end else begin
				o_laser_dac_code <= LPO_DAC_MIN_CURRENT; // [R2]
			end
		end
	end

	// ****************************************************
	// drive pin self-test
	// ****************************************************
	// a new config write restarts the test even mid-sequence [R3]
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tst_ff <= LPO_ST_IDLE;
			tcnt_ff <= 16'h0000;
		end else if (i_wr && sel(i_addr, LPO_ADDR_LASER_CFG)) begin
			tst_ff <= LPO_ST_HIGH; // [R3]
			tcnt_ff <= 16'h0000;
		end else begin
			case (tst_ff)
				LPO_ST_HIGH: begin
					if (tcnt_ff == 16'(TEST_CYC - 1)) begin
						tcnt_ff <= 16'h0000;
						// pin must read back high or it is stuck low
						tst_ff <= i_laser_drive_sense ? LPO_ST_LOW : LPO_ST_FAULT;
					end else begin
						tcnt_ff <= tcnt_ff + 16'h0001;
					end
				end
				LPO_ST_LOW: begin
					if (tcnt_ff == 16'(TEST_CYC - 1)) begin
						tcnt_ff <= 16'h0000;
						tst_ff <= i_laser_drive_sense ? LPO_ST_FAULT : LPO_ST_IDLE; // [R5]
					end else begin
						tcnt_ff <= tcnt_ff + 16'h0001;
					end
				end
				LPO_ST_FAULT: tst_ff <= LPO_ST_FAULT;
				default: tst_ff <= LPO_ST_IDLE;
			endcase
		end
	end

	// fault latches the laser off until the next config write: eye safety first
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_laser_enable_low <= 1'b1;
			o_laser_drive_output <= 1'b0;
			o_laser_fault <= 1'b0;
		end else begin
			o_laser_enable_low <= (tst_ff != LPO_ST_IDLE); // [R4] [R5]
			o_laser_drive_output <= (tst_ff == LPO_ST_HIGH) || (tst_ff == LPO_ST_IDLE); // [R4]
			o_laser_fault <= (tst_ff == LPO_ST_FAULT);
		end
	end

	// ****************************************************
	// observation register
	// ****************************************************
	always_comb begin
		nxt_obs = obs_ff;
		if (i_wr && sel(i_addr, LPO_ADDR_OBSERVE) && i_wdata == 8'h00) begin
			nxt_obs = 8'h00; // [R10]
		end
		// sets come after the clear so a same-cycle event is kept
		nxt_obs[LPO_OBS_FW_BIT] = i_fw_running; // [R12]
		if (i_powerdown_pulse) begin
			nxt_obs[LPO_OBS_PD_BIT] = 1'b1; // [R13]
		end
		if (i_frame_tick) begin
			nxt_obs[LPO_OBS_F1_BIT] = 1'b1; // [R14]
			nxt_obs[LPO_OBS_F0_BIT] = 1'b1; // [R14]
		end
		nxt_obs = nxt_obs & LPO_OBS_IMPL_MASK; // [R14]
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			obs_ff <= LPO_RST_OBSERVE;
		end else begin
			obs_ff <= nxt_obs;
		end
	end

	// ****************************************************
	// read path and streams
	// ****************************************************
	// any non-motion access ends a motion burst so the next one starts at status
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mot_idx_ff <= 3'h0;
		end else if (i_rd && sel(i_addr, LPO_ADDR_MOTION_STREAM)) begin
			mot_idx_ff <= (mot_idx_ff == LPO_MOTION_LEN - 3'h1) ? 3'h0 : mot_idx_ff + 3'h1; // [R17]
		end else if (i_rd || i_wr) begin
			mot_idx_ff <= 3'h0;
		end
	end

	always_comb begin
		nxt_rdata = 8'h00; // [R19]
		case (i_addr)
			LPO_ADDR_LASER_CFG: nxt_rdata = cfg_ff;
			LPO_ADDR_LASER_CMP: nxt_rdata = cmp_ff;
			LPO_ADDR_OBSERVE: nxt_rdata = obs_ff;
			LPO_ADDR_INV_ID: nxt_rdata = ~PRODUCT_IDENTIFICATION; // [R15]
			LPO_ADDR_PIXEL_STREAM: nxt_rdata = i_pixel_data; // [R16]
			LPO_ADDR_MOTION_STREAM: nxt_rdata = i_motion_data[8*mot_idx_ff +: 8]; // [R17]
			default: nxt_rdata = 8'h00; // [R19]
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rdata <= 8'h00;
			o_rvalid <= 1'b0;
			o_pixel_next <= 1'b0;
			o_fw_valid <= 1'b0;
			o_fw_data <= 8'h00;
		end else begin
			o_rvalid <= i_rd;
			o_rdata <= i_rd ? nxt_rdata : 8'h00;
			o_pixel_next <= i_rd && sel(i_addr, LPO_ADDR_PIXEL_STREAM); // [R16]
			o_fw_valid <= i_wr && sel(i_addr, LPO_ADDR_FW_STREAM); // [R18]
			o_fw_data <= i_wdata; // [R18]
		end
	end

	// ****************************************************
	// assertions
	// ****************************************************
	property p_mismatch_min;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		(cmp_ff != ~cfg_ff) |=> (o_laser_dac_code == LPO_DAC_MIN_CURRENT);
	endproperty
	a_mismatch_min: assert property (p_mismatch_min) else $error("mismatch not min"); // [R2]
	property p_match_apply;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		(cmp_ff == ~cfg_ff) |=> (o_laser_dac_code == $past(cfg_ff[6:0]));
	endproperty
	a_match_apply: assert property (p_match_apply) else $error("code not applied"); // [R1]
	property p_test_start;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		(i_wr && i_addr == LPO_ADDR_LASER_CFG) |=> ##1 (o_laser_enable_low && o_laser_drive_output);
	endproperty
	a_test_start: assert property (p_test_start) else $error("test did not start"); // [R3]
	property p_test_en_high;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		(tst_ff == LPO_ST_HIGH) |=> o_laser_enable_low;
	endproperty
	a_test_en_high: assert property (p_test_en_high) else $error("enable low in test"); // [R4]
	property p_pass_normal;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		(tst_ff == LPO_ST_LOW && tcnt_ff == 16'(TEST_CYC - 1) && !i_laser_drive_sense
		&& !i_wr) |=> ##1 (!o_laser_enable_low && o_laser_drive_output);
	endproperty
	a_pass_normal: assert property (p_pass_normal) else $error("pins not back to normal"); // [R5]
	property p_fault_safe;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		(tst_ff == LPO_ST_FAULT) |=> (o_laser_fault && o_laser_enable_low && !o_laser_drive_output);
	endproperty
	a_fault_safe: assert property (p_fault_safe) else $error("fault not held safe"); // [R5]
	property p_obs_clear;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		(i_wr && i_addr == LPO_ADDR_OBSERVE && i_wdata == 8'h00 && !i_powerdown_pulse
		&& !i_frame_tick) |=> (obs_ff[5:0] == 6'h00);
	endproperty
	a_obs_clear: assert property (p_obs_clear) else $error("observation not cleared"); // [R10]
	property p_fw_bit;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		1'b1 |=> (obs_ff[LPO_OBS_FW_BIT] == $past(i_fw_running));
	endproperty
	a_fw_bit: assert property (p_fw_bit) else $error("firmware bit wrong"); // [R12]
	property p_pd_bit;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_powerdown_pulse |=> obs_ff[LPO_OBS_PD_BIT];
	endproperty
	a_pd_bit: assert property (p_pd_bit) else $error("powerdown bit missed"); // [R13]
	property p_reserved;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		(obs_ff & ~LPO_OBS_IMPL_MASK) == 8'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set"); // [R14]
	property p_inv_id;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		(i_rd && i_addr == LPO_ADDR_INV_ID) |=> (o_rdata == ~PRODUCT_IDENTIFICATION);
	endproperty
	a_inv_id: assert property (p_inv_id) else $error("inverse id wrong"); // [R15]
	property p_rsvd_zero;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		(i_rd && i_addr > LPO_ADDR_LASER_CMP && i_addr < LPO_ADDR_OBSERVE) |=> (o_rdata == 8'h00);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read nonzero"); // [R19]
	property p_pixel_read;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		(i_rd && i_addr == LPO_ADDR_PIXEL_STREAM) |=> (o_pixel_next && o_rdata == $past(i_pixel_data));
	endproperty
	a_pixel_read: assert property (p_pixel_read) else $error("pixel read wrong"); // [R16]
	property p_motion_first;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		(i_rd && i_addr == LPO_ADDR_MOTION_STREAM && mot_idx_ff == 3'h0)
		|=> (o_rdata == $past(i_motion_data[7:0]));
	endproperty
	a_motion_first: assert property (p_motion_first) else $error("motion status wrong"); // [R17]
	property p_fw_write;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		(i_wr && i_addr == LPO_ADDR_FW_STREAM) |=> (o_fw_valid && o_fw_data == $past(i_wdata));
	endproperty
	a_fw_write: assert property (p_fw_write) else $error("firmware byte lost"); // [R18]
	c_test: cover property (@(posedge i_ref_clk) tst_ff == LPO_ST_LOW ##1 tst_ff == LPO_ST_IDLE);
	c_fault: cover property (@(posedge i_ref_clk) tst_ff == LPO_ST_FAULT);
	c_obs: cover property (@(posedge i_ref_clk) obs_ff == 8'ha3);
	c_motion_wrap: cover property (@(posedge i_ref_clk) mot_idx_ff == 3'h6 ##1 mot_idx_ff == 3'h0);
endmodule : lpo_regs
`default_nettype wire

// ---- lpo_pin_model.sv ----
// partner model: laser drive pin with a commandable stuck fault
`default_nettype none
module lpo_pin_model (
	// pin side
	input wire logic i_drive,
	output logic o_sense,
	// fault control
	input wire logic i_stuck_en,
	input wire logic i_stuck_val
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************************
	// pin readback
	// ****************************************************
	// a stuck pin ignores the driver, which is what the self-test must catch
	assign o_sense = i_stuck_en ? i_stuck_val : i_drive;
endmodule : lpo_pin_model
`default_nettype wire

// ---- tb_top.sv ----
// testbench: register sequences with expected values for the laser and observation block
`default_nettype none
module tb_top;
	import lpo_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] PID = 8'h5a; // arbitrary value
	localparam int TC = 4;
	logic clk, rst_n, wr, rd, fw, pd, ft, sense, stk, stv;
	logic pnext, fwv, drv, en_n, bin, flt, rv;
	logic [6:0] addr, dac;
	logic [7:0] wd, rdata, pix, fwd;
	logic [55:0] mot;
	int miscompares, cmp_count, cyc;
	lpo_regs #(.PRODUCT_IDENTIFICATION(PID), .TEST_CYC(TC)) dut_u (
		.i_ref_clk(clk), .i_arst_n(rst_n), .i_wr(wr), .i_rd(rd), .i_addr(addr),
		.i_wdata(wd), .o_rdata(rdata), .o_rvalid(rv), .i_fw_running(fw),
		.i_powerdown_pulse(pd), .i_frame_tick(ft), .i_pixel_data(pix),
		.i_motion_data(mot), .o_pixel_next(pnext), .o_fw_valid(fwv), .o_fw_data(fwd),
		.i_laser_drive_sense(sense), .o_laser_drive_output(drv),
		.o_laser_enable_low(en_n), .o_laser_dac_code(dac), .o_bin_match(bin),
		.o_laser_fault(flt)
	);
	lpo_pin_model pin_u (.i_drive(drv), .o_sense(sense), .i_stuck_en(stk), .i_stuck_val(stv));
	// ****************************************************
	// tasks
	// ****************************************************
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		#2;
		wr = 1'b1;
		addr = a;
		wd = d;
		@(posedge clk);
		#2;
		wr = 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [6:0] a, input logic [7:0] exp, input string nm);
		@(posedge clk);
		#2;
		rd = 1'b1;
		addr = a;
		@(posedge clk);
		#2;
		rd = 1'b0;
		chk({nm, " valid"}, {7'h00, rv}, 8'h01);
		chk(nm, rdata, exp);
	endtask : rd_reg
	// checks both test phases, then the end state
	task automatic cfg_write(input logic [7:0] v, input logic f);
		wr_reg(LPO_ADDR_LASER_CFG, v);
		repeat (2) @(posedge clk);
		#2;
		chk("enable high phase", {7'h00, en_n}, 8'h01);
		chk("drive high phase", {7'h00, drv}, 8'h01);
		repeat (4) @(posedge clk);
		#2;
		chk("enable low phase", {7'h00, en_n}, 8'h01);
		chk("drive low phase", {7'h00, drv}, 8'h00);
		repeat (6) @(posedge clk);
		#2;
		chk("fault", {7'h00, flt}, {7'h00, f});
		chk("enable after test", {7'h00, en_n}, {7'h00, f});
		if (!f) chk("drive after test", {7'h00, drv}, 8'h01);
	endtask : cfg_write
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	// ****************************************************
	// clock, timeout and sequence
	// ****************************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ceiling is well above the roughly 130 cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			final_report();
		end
	end
	initial begin
		{rst_n, wr, rd, fw, pd, ft, stk, stv} = 8'h00;
		addr = 7'h00;
		wd = 8'h00;
		pix = 8'h3c;
		mot = 56'h77665544332211;
		repeat (2) @(posedge clk);
		#2;
		rst_n = 1'b1;
		@(posedge clk);
		#2;
		chk("dac after reset", {1'b0, dac}, 8'h7f);
		chk("enable after reset", {7'h00, en_n}, 8'h00);
		rd_reg(LPO_ADDR_LASER_CFG, 8'h7f, "cfg reset");
		rd_reg(LPO_ADDR_LASER_CMP, 8'h80, "cmp reset");
		rd_reg(LPO_ADDR_INV_ID, ~PID, "inverse id");
		cfg_write(8'h85, 1'b0);
		chk("dac mismatch", {1'b0, dac}, 8'h7f);
		chk("bin match", {7'h00, bin}, 8'h01);
		wr_reg(LPO_ADDR_LASER_CMP, 8'h7a);
		repeat (2) @(posedge clk);
		#2;
		chk("dac matched", {1'b0, dac}, 8'h05);
		rd_reg(LPO_ADDR_LASER_CFG, 8'h85, "cfg readback");
		wr_reg(LPO_ADDR_LASER_CMP, 8'hff);
		repeat (2) @(posedge clk);
		#2;
		chk("dac cmp first", {1'b0, dac}, 8'h7f);
		cfg_write(8'h00, 1'b0);
		chk("dac full current", {1'b0, dac}, 8'h00);
		chk("bin clear", {7'h00, bin}, 8'h00);
		stk = 1'b1;
		cfg_write(8'h00, 1'b1);
		stv = 1'b1;
		cfg_write(8'h00, 1'b1);
		stk = 1'b0;
		cfg_write(8'h00, 1'b0);
		fw = 1'b1;
		@(posedge clk);
		#2;
		{pd, ft} = 2'b11;
		@(posedge clk);
		#2;
		{pd, ft} = 2'b00;
		rd_reg(LPO_ADDR_OBSERVE, 8'ha3, "obs set");
		wr_reg(LPO_ADDR_OBSERVE, 8'hff);
		rd_reg(LPO_ADDR_OBSERVE, 8'ha3, "obs nonzero write");
		wr_reg(LPO_ADDR_OBSERVE, 8'h00);
		rd_reg(LPO_ADDR_OBSERVE, 8'h80, "obs cleared");
		fw = 1'b0;
		rd_reg(LPO_ADDR_OBSERVE, 8'h00, "obs fw off");
		wr_reg(7'h30, 8'hff);
		rd_reg(7'h30, 8'h00, "reserved 30");
		rd_reg(7'h3e, 8'h00, "reserved 3e");
		rd_reg(LPO_ADDR_LASER_CFG, 8'h00, "cfg untouched");
		for (int i = 0; i < 8; i++) rd_reg(LPO_ADDR_MOTION_STREAM, mot[8*(i%7)+:8], "motion");
		rd_reg(LPO_ADDR_PIXEL_STREAM, 8'h3c, "pixel");
		chk("pixel next", {7'h00, pnext}, 8'h01);
		wr_reg(LPO_ADDR_FW_STREAM, 8'hc4);
		chk("fw valid", {7'h00, fwv}, 8'h01);
		chk("fw data", fwd, 8'hc4);
		final_report();
	end
endmodule : tb_top
`default_nettype wire
